// [fifo_port_retransmit_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - at master reset latch latency strap; low zero latency, high normal latency
// - rewind on read edge zeroes read pointer address bits (wrap bit follows write pointer), forces empty/not-ready flags
// - rewind keeps write pointer, mode, offsets and straps untouched
// - offset serial load happens only while shift enable is asserted
// - synchronous write stores data on write edge only with write enable
// - in synchronous write mode, write enable gates both memory writes and offset loads
// - asynchronous write stores data on every write strobe rising edge while not full
// - at master reset latch read strap; high synchronous, low asynchronous
// - at master reset latch write strap; high synchronous, low asynchronous
// - master reset zeroes both pointers and the output register
// - at master reset input width strap low gives 18 bits, high 9
module fifo_port_retransmit_ctrl #(
  parameter int DEPTH = fifo_port_pkg::DEPTH_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fifo_port_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [fifo_port_pkg::WB_SEL_W-1:0] wb_sel_i,
  input wire logic [fifo_port_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [fifo_port_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic master_rst_n_i,
  input wire logic wr_clk_i,
  input wire logic wr_en_n_i,
  input wire logic [fifo_port_pkg::DATA_W-1:0] data_i,
  input wire logic rd_clk_i,
  input wire logic rd_en_n_i,
  input wire logic rewind_req_n_i,
  input wire logic offset_shift_en_n_i,
  input wire logic retx_latency_sel_i,
  input wire logic rd_port_sync_sel_i,
  input wire logic wr_port_sync_sel_i,
  input wire logic fall_through_mode_i,
  input wire logic in_width_sel_i,
  output logic [fifo_port_pkg::DATA_W-1:0] data_o,
  output logic empty_flag_n_o,
  output logic out_ready_n_o,
  output logic full_flag_n_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int DW = fifo_port_pkg::DATA_W;
  localparam int NW = fifo_port_pkg::NARROW_W;
  localparam int HW = fifo_port_pkg::HOLD_W;
  localparam int IN = fifo_port_pkg::IRQ_N;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [DW-1:0] dout;
    logic out_valid;
    logic [HW-1:0] hold;
    logic [AW-1:0] empty_off;
    logic [AW-1:0] full_off;
    logic retx_zero;
    logic rd_sync;
    logic wr_sync;
    logic fall_through_mode;
    logic narrow;
    logic [IN-1:0] irq_stat;
    logic [IN-1:0] irq_mask;
    logic ack;
    logic [fifo_port_pkg::WB_DAT_W-1:0] rdat;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sync_if #(.W(fifo_port_pkg::CLK_N)) clk_s ();
  sync_if #(.W(fifo_port_pkg::CB_W)) ctl_s ();

  pin_sync #(.W(fifo_port_pkg::CLK_N)) u_clk_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i({rd_clk_i, wr_clk_i}),
    .out(clk_s)
  );

  // data rides with the controls so both see the same latency as the clocks
  pin_sync #(.W(fifo_port_pkg::CB_W)) u_ctl_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i({data_i, in_width_sel_i, fall_through_mode_i, wr_port_sync_sel_i, rd_port_sync_sel_i,
            retx_latency_sel_i, offset_shift_en_n_i, rewind_req_n_i, rd_en_n_i, wr_en_n_i,
            master_rst_n_i}),
    .out(ctl_s)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic mrst;
  logic wr_edge;
  logic rd_edge;
  logic wen;
  logic ren;
  logic shift_en;
  logic [DW-1:0] din;
  logic [AW:0] count;
  logic empty;
  logic full;
  logic load_go;
  logic mem_go;
  logic rewind_go;
  logic holding;
  logic rd_req;
  logic rd_go;
  logic fall_through_mode_pop;
  logic fall_through_mode_fill;
  logic [2*AW:0] shifted;
  logic [IN-1:0] events;
  logic wb_req;
  logic [IN-1:0] clr;

  assign mrst = ~ctl_s.level[fifo_port_pkg::CB_MRST_N];
  assign wr_edge = clk_s.rise[fifo_port_pkg::CLK_WR];
  assign rd_edge = clk_s.rise[fifo_port_pkg::CLK_RD];
  assign wen = ~ctl_s.level[fifo_port_pkg::CB_WEN_N];
  assign ren = ~ctl_s.level[fifo_port_pkg::CB_REN_N];
  assign shift_en = ~ctl_s.level[fifo_port_pkg::CB_SHIFT_N];
  assign din = s_q.narrow ? {{(DW-NW){1'b0}}, ctl_s.level[fifo_port_pkg::CB_DATA_LSB +: NW]}
                          : ctl_s.level[fifo_port_pkg::CB_DATA_LSB +: DW];
  assign count = s_q.wptr - s_q.rptr;
  assign empty = (count == '0);
  assign full = (count == (AW + 1)'(DEPTH));
  assign holding = (s_q.hold != '0);

  assign load_go = wr_edge & s_q.wr_sync & wen & shift_en;
  assign mem_go = wr_edge & (s_q.wr_sync ? (wen & ~shift_en) : 1'b1);
  assign rewind_go = rd_edge & ~ctl_s.level[fifo_port_pkg::CB_REWIND_N];
  assign rd_req = rd_edge & (s_q.rd_sync ? ren : 1'b1);
  assign rd_go = ~s_q.fall_through_mode & rd_req & ~empty & ~holding & ~rewind_go;
  assign fall_through_mode_pop = s_q.fall_through_mode & rd_edge & ren & s_q.out_valid & ~holding & ~rewind_go;
  assign fall_through_mode_fill = s_q.fall_through_mode & rd_edge & (~s_q.out_valid | fall_through_mode_pop) & ~empty & ~holding & ~rewind_go;
  assign shifted = {s_q.full_off, s_q.empty_off, din[0]};

  assign events[fifo_port_pkg::IRQ_OVERFLOW] = mem_go & full;
  assign events[fifo_port_pkg::IRQ_UNDERFLOW] = s_q.fall_through_mode ? (rd_edge & ren & ~s_q.out_valid)
                                                         : (rd_req & empty & ~holding);
  assign events[fifo_port_pkg::IRQ_REWIND_DONE] = rd_edge & (s_q.hold == HW'(1));
  assign events[fifo_port_pkg::IRQ_OFFSET_LOAD] = load_go;

  assign wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign clr = (wb_req & wb_we_i & wb_sel_i[0] && wb_adr_i == fifo_port_pkg::ADR_IRQ_STAT) ? wb_dat_i[IN-1:0]
                                                                                          : '0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (mem_go && !full) begin
      s_d.mem[s_q.wptr[AW-1:0]] = din;
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (load_go) begin
      s_d.empty_off = shifted[AW-1:0];
      s_d.full_off = shifted[2*AW-1:AW];
    end
    if (rewind_go) begin
      // wrap bit follows the writer so the count stays the written span
      s_d.rptr = {s_q.wptr[AW], {AW{1'b0}}};
      s_d.out_valid = 1'b0;
      s_d.hold = s_q.retx_zero ? HW'(fifo_port_pkg::RETX_ZERO_EDGES)
                               : HW'(fifo_port_pkg::RETX_NORMAL_EDGES);
    end else if (rd_edge && holding) begin
      s_d.hold = s_q.hold - 1'b1;
    end
    if (rd_go || fall_through_mode_fill) begin
      s_d.dout = s_q.mem[s_q.rptr[AW-1:0]];
      s_d.rptr = s_q.rptr + 1'b1;
      s_d.out_valid = s_q.fall_through_mode;
    end else if (fall_through_mode_pop) begin
      s_d.out_valid = 1'b0;
    end
    if (mrst) begin
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.dout = '0;
      s_d.out_valid = 1'b0;
      s_d.hold = '0;
      s_d.empty_off = AW'(fifo_port_pkg::OFFSET_DEF);
      s_d.full_off = AW'(fifo_port_pkg::OFFSET_DEF);
      s_d.retx_zero = ~ctl_s.level[fifo_port_pkg::CB_RETX_SEL];
      s_d.rd_sync = ctl_s.level[fifo_port_pkg::CB_RD_SYNC];
      s_d.wr_sync = ctl_s.level[fifo_port_pkg::CB_WR_SYNC];
      // fall-through with an asynchronous read port is refused
      s_d.fall_through_mode = ctl_s.level[fifo_port_pkg::CB_FALL_THROUGH_MODE] & ctl_s.level[fifo_port_pkg::CB_RD_SYNC];
      s_d.narrow = ctl_s.level[fifo_port_pkg::CB_IN_W];
    end
    // event set wins over a same-cycle clear
    s_d.irq_stat = (s_q.irq_stat & ~clr) | events;
    if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == fifo_port_pkg::ADR_IRQ_MASK) begin
      s_d.irq_mask = wb_dat_i[IN-1:0];
    end
    s_d.ack = wb_req;
    s_d.rdat = fifo_port_pkg::RD_ZERO;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        fifo_port_pkg::ADR_CONFIG: begin
          s_d.rdat[fifo_port_pkg::CFG_RETX_ZERO] = s_q.retx_zero;
          s_d.rdat[fifo_port_pkg::CFG_RD_SYNC] = s_q.rd_sync;
          s_d.rdat[fifo_port_pkg::CFG_WR_SYNC] = s_q.wr_sync;
          s_d.rdat[fifo_port_pkg::CFG_FALL_THROUGH_MODE] = s_q.fall_through_mode;
          s_d.rdat[fifo_port_pkg::CFG_NARROW] = s_q.narrow;
        end
        fifo_port_pkg::ADR_STATUS: begin
          s_d.rdat[fifo_port_pkg::ST_EMPTY] = empty;
          s_d.rdat[fifo_port_pkg::ST_FULL] = full;
          s_d.rdat[fifo_port_pkg::ST_ALMOST_EMPTY] = (count < {1'b0, s_q.empty_off});
          s_d.rdat[fifo_port_pkg::ST_ALMOST_FULL] = ((AW + 1)'(DEPTH) - count <= {1'b0, s_q.full_off});
          s_d.rdat[fifo_port_pkg::ST_COUNT_LSB +: AW + 1] = count;
        end
        fifo_port_pkg::ADR_IRQ_STAT: begin
          s_d.rdat[IN-1:0] = s_q.irq_stat;
        end
        fifo_port_pkg::ADR_IRQ_MASK: begin
          s_d.rdat[IN-1:0] = s_q.irq_mask;
        end
        fifo_port_pkg::ADR_OFFSETS: begin
          s_d.rdat[AW-1:0] = s_q.empty_off;
          s_d.rdat[fifo_port_pkg::OFS_FULL_LSB +: AW] = s_q.full_off;
        end
        default: begin
          s_d.rdat = fifo_port_pkg::RD_ZERO;
        end
      endcase
    end
    if (rst_i) begin
      s_d = '0;
      s_d.empty_off = AW'(fifo_port_pkg::OFFSET_DEF);
      s_d.full_off = AW'(fifo_port_pkg::OFFSET_DEF);
      s_d.rd_sync = 1'b1;
      s_d.wr_sync = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
  assign data_o = s_q.dout;
  assign empty_flag_n_o = s_q.fall_through_mode | ~(empty | holding);
  assign out_ready_n_o = ~s_q.fall_through_mode | ~(s_q.out_valid & ~holding);
  assign full_flag_n_o = ~full;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_rewind_ptr;
    @(posedge clk_i) disable iff (rst_i)
    (rewind_go && !mrst) |=> (s_q.rptr[AW-1:0] == '0);
  endproperty
  a_rewind_ptr: assert property (p_rewind_ptr) else $error("read pointer not rewound");

  property p_rewind_flag;
    @(posedge clk_i) disable iff (rst_i)
    (rewind_go && !mrst) |=> (!empty_flag_n_o || s_q.fall_through_mode) && out_ready_n_o;
  endproperty
  a_rewind_flag: assert property (p_rewind_flag) else $error("flags not forced by rewind");

  property p_rewind_keep;
    @(posedge clk_i) disable iff (rst_i)
    (rewind_go && !mrst && !mem_go && !load_go) |=>
      $stable(s_q.wptr) && $stable({s_q.empty_off, s_q.full_off, s_q.fall_through_mode, s_q.retx_zero});
  endproperty
  a_rewind_keep: assert property (p_rewind_keep) else $error("rewind disturbed write side");

  property p_offset_gate;
    @(posedge clk_i) disable iff (rst_i)
    (!mrst && !(wr_edge && wen && shift_en)) |=> $stable({s_q.empty_off, s_q.full_off});
  endproperty
  a_offset_gate: assert property (p_offset_gate) else $error("offset changed without enables");

  property p_sync_wr_gate;
    @(posedge clk_i) disable iff (rst_i)
    (!mrst && s_q.wr_sync && !(wr_edge && wen)) |=> $stable(s_q.wptr);
  endproperty
  a_sync_wr_gate: assert property (p_sync_wr_gate) else $error("write without enabled edge");

  property p_async_wr;
    @(posedge clk_i) disable iff (rst_i)
    (!mrst && !s_q.wr_sync && wr_edge && !full) |=> (s_q.wptr == $past(s_q.wptr) + 1'b1);
  endproperty
  a_async_wr: assert property (p_async_wr) else $error("strobe write not stored");

  property p_strap_latch;
    @(posedge clk_i) disable iff (rst_i)
    mrst |=> (s_q.retx_zero == !$past(ctl_s.level[fifo_port_pkg::CB_RETX_SEL]))
          && (s_q.rd_sync == $past(ctl_s.level[fifo_port_pkg::CB_RD_SYNC]))
          && (s_q.wr_sync == $past(ctl_s.level[fifo_port_pkg::CB_WR_SYNC]))
          && (s_q.narrow == $past(ctl_s.level[fifo_port_pkg::CB_IN_W]));
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("strap not latched");

  property p_mrst_clear;
    @(posedge clk_i) disable iff (rst_i)
    mrst |=> (s_q.wptr == '0) && (s_q.rptr == '0) && (data_o == '0) ##1 !s_q.fall_through_mode || s_q.rd_sync;
  endproperty
  a_mrst_clear: assert property (p_mrst_clear) else $error("master reset left state");

  property p_normal_latency;
    @(posedge clk_i) disable iff (rst_i)
    (rewind_go && !mrst && !s_q.retx_zero) |=> (s_q.hold == HW'(fifo_port_pkg::RETX_NORMAL_EDGES));
  endproperty
  a_normal_latency: assert property (p_normal_latency) else $error("normal latency not applied");

endmodule : fifo_port_retransmit_ctrl

// [fifo_port_pkg.sv]
package fifo_port_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int NARROW_W = 9;
  localparam int DEPTH_DEF = 512;
  localparam int OFFSET_DEF = 7;
  localparam int HOLD_W = 2;
  localparam int RETX_ZERO_EDGES = 1;
  localparam int RETX_NORMAL_EDGES = 3;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam logic [WB_ADR_W-1:0] ADR_CONFIG = 8'h00;
  localparam logic [WB_ADR_W-1:0] ADR_STATUS = 8'h04;
  localparam logic [WB_ADR_W-1:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [WB_ADR_W-1:0] ADR_IRQ_MASK = 8'h0C;
  localparam logic [WB_ADR_W-1:0] ADR_OFFSETS = 8'h10;
  localparam logic [WB_DAT_W-1:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_RETX_ZERO = 0;
  localparam int CFG_RD_SYNC = 1;
  localparam int CFG_WR_SYNC = 2;
  localparam int CFG_FALL_THROUGH_MODE = 3;
  localparam int CFG_NARROW = 4;
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_ALMOST_EMPTY = 2;
  localparam int ST_ALMOST_FULL = 3;
  localparam int ST_COUNT_LSB = 16;
  localparam int OFS_FULL_LSB = 16;
  localparam int IRQ_N = 4;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_UNDERFLOW = 1;
  localparam int IRQ_REWIND_DONE = 2;
  localparam int IRQ_OFFSET_LOAD = 3;

  // ----------------------------------------------------------------
  // synchroniser bundles
  // ----------------------------------------------------------------
  localparam int CLK_WR = 0;
  localparam int CLK_RD = 1;
  localparam int CLK_N = 2;
  localparam int CB_MRST_N = 0;
  localparam int CB_WEN_N = 1;
  localparam int CB_REN_N = 2;
  localparam int CB_REWIND_N = 3;
  localparam int CB_SHIFT_N = 4;
  localparam int CB_RETX_SEL = 5;
  localparam int CB_RD_SYNC = 6;
  localparam int CB_WR_SYNC = 7;
  localparam int CB_FALL_THROUGH_MODE = 8;
  localparam int CB_IN_W = 9;
  localparam int CB_DATA_LSB = 10;
  localparam int CB_W = CB_DATA_LSB + DATA_W;

endpackage : fifo_port_pkg

// [sync_if.sv]
`timescale 1ns/1ps
interface sync_if #(
  parameter int W = 1
);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : sync_if

// [pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] raw_i,
  sync_if.src out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stage;
    logic [W-1:0] prev;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // ----------------------------------------------------------------
  // two flops, then edge detect on the second only
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.meta = raw_i;
    s_d.stage = s_q.meta;
    s_d.prev = s_q.stage;
    if (rst_i) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign out.level = s_q.stage;
  assign out.rise = s_q.stage & ~s_q.prev;

endmodule : pin_sync

// [fifo_port_partner.sv]
`timescale 1ns/1ps
module fifo_port_partner (
  input wire logic clk_i,
  output logic wr_clk_o,
  output logic wr_en_n_o,
  output logic [fifo_port_pkg::DATA_W-1:0] data_o,
  output logic rd_clk_o,
  output logic rd_en_n_o,
  output logic rewind_req_n_o,
  output logic offset_shift_en_n_o
);
  // ----------------------------------------
  // writer and reader pins
  // ----------------------------------------
  // half of the 160 ns link period, in clk_i cycles
  localparam int HALF = 16;

  initial begin
    wr_clk_o = 1'b0;
    wr_en_n_o = 1'b1;
    data_o = '0;
    rd_clk_o = 1'b0;
    rd_en_n_o = 1'b1;
    rewind_req_n_o = 1'b1;
    offset_shift_en_n_o = 1'b1;
  end

  // one write clock or strobe pulse; clock stands low between frames
  task automatic put_word(input logic [fifo_port_pkg::DATA_W-1:0] d, input logic wen_n, input logic sen_n);
    @(posedge clk_i);
    data_o <= d;
    wr_en_n_o <= wen_n;
    offset_shift_en_n_o <= sen_n;
    repeat (HALF) @(posedge clk_i);
    wr_clk_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    wr_clk_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    // released bus must not keep showing the old word
    data_o <= ~d;
    offset_shift_en_n_o <= 1'b1;
  endtask : put_word

  // one read clock or strobe pulse with enable and rewind request
  task automatic take_edge(input logic ren_n, input logic rt_n);
    @(posedge clk_i);
    rd_en_n_o <= ren_n;
    rewind_req_n_o <= rt_n;
    repeat (HALF) @(posedge clk_i);
    rd_clk_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    rd_clk_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    rd_en_n_o <= 1'b1;
    rewind_req_n_o <= 1'b1;
  endtask : take_edge
endmodule : fifo_port_partner

// [fifo_port_retransmit_ctrl_bench.sv]
`timescale 1ns/1ps
module fifo_port_retransmit_ctrl_bench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, master_rst_n_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic wr_clk, wr_en_n, rd_clk, rd_en_n, rewind_n, shift_n;
  logic retx_sel, rd_sync, wr_sync, fall_through_mode, in_w, empty_n, ready_n, full_n;
  logic [17:0] din, dout;
  int failures, n_tests, i;

  fifo_port_partner u_partner (.clk_i(clk_i), .wr_clk_o(wr_clk), .wr_en_n_o(wr_en_n), .data_o(din),
    .rd_clk_o(rd_clk), .rd_en_n_o(rd_en_n), .rewind_req_n_o(rewind_n), .offset_shift_en_n_o(shift_n));

  fifo_port_retransmit_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .master_rst_n_i(master_rst_n_i), .wr_clk_i(wr_clk),
    .wr_en_n_i(wr_en_n), .data_i(din), .rd_clk_i(rd_clk), .rd_en_n_i(rd_en_n), .rewind_req_n_i(rewind_n),
    .offset_shift_en_n_i(shift_n), .retx_latency_sel_i(retx_sel), .rd_port_sync_sel_i(rd_sync),
    .wr_port_sync_sel_i(wr_sync), .fall_through_mode_i(fall_through_mode), .in_width_sel_i(in_w), .data_o(dout),
    .empty_flag_n_o(empty_n), .out_ready_n_o(ready_n), .full_flag_n_o(full_n));

  // ----------------------------------------
  // clock, checks, closing
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // register bus and strap tasks
  // ----------------------------------------
  // ack and read data are taken at the rising edge; the request stands until then
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) failures++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk

  // s = {width, fall-through, write sync, read sync, latency}
  task automatic master_reset(input logic [4:0] s);
    @(posedge clk_i);
    master_rst_n_i <= 1'b0;
    {in_w, fall_through_mode, wr_sync, rd_sync, retx_sel} <= s;
    repeat (10) @(posedge clk_i);
    master_rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : master_reset

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    failures = 0;
    n_tests = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, master_rst_n_i} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {in_w, fall_through_mode, wr_sync, rd_sync, retx_sel} = 5'h07;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    master_reset(5'h07);
    rd_chk(fifo_port_pkg::ADR_CONFIG, 32'h0000_0006);
    rd_chk(fifo_port_pkg::ADR_STATUS, 32'h0000_0005);
    check({14'h0000, dout}, 32'h0000_0000);
    wb_xfer(1'b1, fifo_port_pkg::ADR_CONFIG, 32'h0000_001F);
    wb_xfer(1'b1, 8'h40, 32'h0000_FFFF);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(fifo_port_pkg::ADR_CONFIG, 32'h0000_0006);
    u_partner.put_word(18'h3_FFFF, 1'b1, 1'b0);
    rd_chk(fifo_port_pkg::ADR_OFFSETS, 32'h0007_0007);
    for (i = 0; i < 18; i++) u_partner.put_word(18'h0_0001, 1'b0, 1'b0);
    rd_chk(fifo_port_pkg::ADR_OFFSETS, 32'h01FF_01FF);
    rd_chk(fifo_port_pkg::ADR_STATUS, 32'h0000_0005);
    for (i = 0; i < 3; i++) u_partner.put_word(18'h2_A5A0 + 18'(i), 1'b0, 1'b1);
    u_partner.put_word(18'h0_0BAD, 1'b1, 1'b1);
    // free space 509 is within the full offset of 511, so almost full is up
    rd_chk(fifo_port_pkg::ADR_STATUS, 32'h0003_000C);
    u_partner.take_edge(1'b0, 1'b1);
    check({14'h0000, dout}, 32'h0002_A5A0);
    u_partner.take_edge(1'b1, 1'b0);
    check({31'h0, empty_n}, 32'h0000_0000);
    repeat (3) u_partner.take_edge(1'b1, 1'b1);
    check({31'h0, empty_n}, 32'h0000_0001);
    rd_chk(fifo_port_pkg::ADR_STATUS, 32'h0003_000C);
    rd_chk(fifo_port_pkg::ADR_OFFSETS, 32'h01FF_01FF);
    rd_chk(fifo_port_pkg::ADR_CONFIG, 32'h0000_0006);
    u_partner.take_edge(1'b0, 1'b1);
    check({14'h0000, dout}, 32'h0002_A5A0);
    // interrupt: masked, unmasked, cleared
    check({31'h0, irq_o}, 32'h0000_0000);
    wb_xfer(1'b1, fifo_port_pkg::ADR_IRQ_MASK, 32'h0000_0004);
    check({31'h0, irq_o}, 32'h0000_0001);
    wb_xfer(1'b1, fifo_port_pkg::ADR_IRQ_STAT, 32'h0000_0004);
    check({31'h0, irq_o}, 32'h0000_0000);
    // async ports, narrow input; fall-through refused with async read
    master_reset(5'h18);
    rd_chk(fifo_port_pkg::ADR_CONFIG, 32'h0000_0011);
    rd_chk(fifo_port_pkg::ADR_STATUS, 32'h0000_0005);
    rd_chk(fifo_port_pkg::ADR_OFFSETS, 32'h0007_0007);
    u_partner.put_word(18'h3_FE5A, 1'b0, 1'b1);
    u_partner.put_word(18'h0_0033, 1'b0, 1'b1);
    rd_chk(fifo_port_pkg::ADR_STATUS, 32'h0002_0004);
    u_partner.take_edge(1'b1, 1'b1);
    check({14'h0000, dout}, 32'h0000_005A);
    u_partner.take_edge(1'b1, 1'b0);
    check({31'h0, empty_n}, 32'h0000_0000);
    u_partner.take_edge(1'b1, 1'b1);
    check({31'h0, empty_n}, 32'h0000_0001);
    // fall-through with synchronous ports
    master_reset(5'h0F);
    rd_chk(fifo_port_pkg::ADR_CONFIG, 32'h0000_000E);
    u_partner.put_word(18'h1_2345, 1'b0, 1'b1);
    u_partner.take_edge(1'b1, 1'b1);
    check({31'h0, ready_n}, 32'h0000_0000);
    check({14'h0000, dout}, 32'h0001_2345);
    check({31'h0, empty_n}, 32'h0000_0001);
    check({31'h0, full_n}, 32'h0000_0001);
    u_partner.take_edge(1'b1, 1'b0);
    check({31'h0, ready_n}, 32'h0000_0001);
    check({14'h0000, dout}, 32'h0001_2345);
    close_out();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule : fifo_port_retransmit_ctrl_bench
